//--- common/dmam_pkg.sv
// Package of the default memory attribute map.
// Assumes a 32-bit address space and one processor clock.
package dmam_pkg;
   // ============================================================
   // Region bounds
   localparam logic [31:0] DMAM_CODE_LO = 32'h0000_0000;
   localparam logic [31:0] DMAM_SRAM_LO = 32'h2000_0000;
   localparam logic [31:0] DMAM_SRAM_HI = 32'h3FFF_FFFF;
   localparam logic [31:0] DMAM_PERI_LO = 32'h4000_0000;
   localparam logic [31:0] DMAM_XRAM_LO = 32'h6000_0000;
   localparam logic [31:0] DMAM_XRAM_HI = 32'h9FFF_FFFF;
   localparam logic [31:0] DMAM_XDEV_LO = 32'hA000_0000;
   localparam logic [31:0] DMAM_XDEV_HI = 32'hDFFF_FFFF;
   localparam logic [31:0] DMAM_PPB_LO  = 32'hE000_0000;
   localparam logic [31:0] DMAM_PPB_HI  = 32'hE00F_FFFF;
   // ============================================================
   // Counters and reset values
   localparam int          DMAM_CNT_W   = 4;
   localparam logic [3:0]  DMAM_CNT_MAX = 4'hF;
   localparam logic [3:0]  DMAM_CNT_RST = 4'h0;
   // ============================================================
   // Types
   typedef enum logic [2:0] {
      DMAM_RG_CODE, DMAM_RG_SRAM, DMAM_RG_PERI, DMAM_RG_XRAM,
      DMAM_RG_XDEV, DMAM_RG_PPB, DMAM_RG_RESV
   } dmam_region_t;
   typedef enum logic [1:0] {
      DMAM_MT_NORMAL, DMAM_MT_DEVICE, DMAM_MT_STRONG, DMAM_MT_NONE
   } dmam_mtype_t;
   typedef enum logic [1:0] {
      DMAM_BAR_DATA_ORDER, DMAM_BAR_DATA_SYNC, DMAM_BAR_INSTR_SYNC
   } dmam_bar_t;
   typedef struct packed {
      dmam_region_t region;
      dmam_mtype_t  mtype;
      logic         execute_never;
      logic         reserved;
   } dmam_attr_t;
   typedef struct packed {
      logic         enable;
      logic         hit;
      dmam_mtype_t  mtype;
      logic         execute_never;
   } dmam_prot_t;
endpackage

//--- design/dmam_map.sv
// Default memory attribute map with access ordering and barriers.
// Assumes the core keeps one request per cycle and pulses done once
// for each issued transaction.
//
// How it works
// - Low code space decodes Normal, executable.
// - Data memory range decodes Normal, executable.
// - Peripheral range decodes Device, execute-never.
// - External data range decodes Normal, executable.
// - External device range decodes Device, execute-never.
// - Private peripheral range decodes Strongly Ordered.
// - Execute-never faults only on execution.
// - Ordering kept per memory type.
// - Device writes bufferable, strongly ordered never.
// - Protection unit attributes override the defaults outside reserved space.
// - Prefetch and speculative fetch always allowed.
// - Accesses issue strictly in program order.
// - Data order barrier drains before next access.
// - Data sync barrier drains before execution.
// - Instruction sync barrier flushes prefetched instructions.
// - Order barrier makes updated vector visible.
// - Flush after code change refetches instructions.
// - Priority change effective after sync barrier.
// - Map switch effective after sync barrier.
// - Strongly ordered accesses kept ordered by hardware.
// - Protection change effective; exception entry flushes.
`timescale 1ns/1ps
module dmam_map
   import dmam_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire dmam_prot_t   fetch_prot,
   input  wire logic         fetch_valid,
   input  wire logic [31:0]  fetch_addr,
   output logic              fetch_attr_valid_q,
   output dmam_attr_t        fetch_attr_q,
   input  wire logic         exec_valid,
   input  wire logic         exec_xn,
   input  wire logic         exc_entry,
   output logic              exec_ready,
   output logic              xn_fault_q,
   output logic              flush_q,
   input  wire dmam_prot_t   data_prot,
   input  wire logic         req_valid,
   input  wire logic [31:0]  req_addr,
   input  wire logic         req_write,
   output logic              req_ready,
   output logic              issue_valid_q,
   output logic [31:0]       issue_addr_q,
   output logic              issue_write_q,
   output dmam_attr_t        issue_attr_q,
   output logic              issue_buf_q,
   output logic              bus_err_q,
   input  wire logic         done,
   input  wire logic         bar_valid,
   input  wire dmam_bar_t    bar_op,
   output logic              bar_ready,
   output logic              sync_done_q
);
   // ============================================================
   // Address decode
   function automatic dmam_attr_t dmam_decode(input logic [31:0] a);
      dmam_attr_t r;
      r = '{DMAM_RG_RESV, DMAM_MT_NONE, 1'b1, 1'b1};
      if (a >= DMAM_CODE_LO && a < DMAM_SRAM_LO) begin
         r = '{DMAM_RG_CODE, DMAM_MT_NORMAL, 1'b0, 1'b0};
      end else if (a <= DMAM_SRAM_HI) begin
         r = '{DMAM_RG_SRAM, DMAM_MT_NORMAL, 1'b0, 1'b0};
      end else if (a >= DMAM_PERI_LO && a < DMAM_XRAM_LO) begin
         r = '{DMAM_RG_PERI, DMAM_MT_DEVICE, 1'b1, 1'b0};
      end else if (a <= DMAM_XRAM_HI) begin
         r = '{DMAM_RG_XRAM, DMAM_MT_NORMAL, 1'b0, 1'b0};
      end else if (a >= DMAM_XDEV_LO && a <= DMAM_XDEV_HI) begin
         r = '{DMAM_RG_XDEV, DMAM_MT_DEVICE, 1'b1, 1'b0};
      end else if (a >= DMAM_PPB_LO && a <= DMAM_PPB_HI) begin
         r = '{DMAM_RG_PPB, DMAM_MT_STRONG, 1'b1, 1'b0};
      end
      return r;
   endfunction

   // Protection unit hit replaces type and execute-never, except in reserved space.
   function automatic dmam_attr_t dmam_apply(input dmam_attr_t d,
                                             input dmam_prot_t p);
      dmam_attr_t r;
      r = d;
      if (p.enable && p.hit && !d.reserved) begin
         r.mtype         = p.mtype;
         r.execute_never = p.execute_never;
      end
      return r;
   endfunction

   // ============================================================
   // Barrier state
   typedef enum logic [1:0] {
      DMAM_ST_IDLE, DMAM_ST_ORDER, DMAM_ST_SYNC
   } dmam_state_t;

   dmam_state_t          state_q;
   dmam_state_t          state_d;
   logic [DMAM_CNT_W-1:0] out_q;
   logic [DMAM_CNT_W-1:0] out_d;
   logic [DMAM_CNT_W-1:0] strong_q;
   logic [DMAM_CNT_W-1:0] strong_d;

   wire dmam_attr_t f_attr = dmam_apply(dmam_decode(fetch_addr), fetch_prot);
   wire dmam_attr_t d_attr = dmam_apply(dmam_decode(req_addr), data_prot);
   wire logic d_strong     = (d_attr.mtype == DMAM_MT_STRONG);
   wire logic d_device     = (d_attr.mtype == DMAM_MT_DEVICE);
   wire logic idle         = (state_q == DMAM_ST_IDLE);
   wire logic drained      = (out_q == DMAM_CNT_RST);
   wire logic cnt_room     = (out_q != DMAM_CNT_MAX);
   // Strongly ordered waits for everything; others wait behind it.
   wire logic order_ok     = d_strong ? drained : (strong_q == DMAM_CNT_RST);
   wire logic take         = req_valid && req_ready;
   wire logic take_ok      = take && !d_attr.reserved;
   wire logic bar_take     = bar_valid && bar_ready;
   wire logic dec          = done && (out_q != DMAM_CNT_RST);
   wire logic dec_strong   = done && (strong_q != DMAM_CNT_RST) && (out_q == strong_q);

   assign req_ready  = idle && order_ok && cnt_room && !reset;
   assign bar_ready  = idle && !reset;
   assign exec_ready = (state_q != DMAM_ST_SYNC) && !reset;

   // ============================================================
   // Barrier sequencing
   always_comb begin
      state_d = state_q;
      case (state_q)
         DMAM_ST_IDLE: begin
            if (bar_take && bar_op == DMAM_BAR_DATA_ORDER) begin
               state_d = DMAM_ST_ORDER;
            end else if (bar_take && bar_op == DMAM_BAR_DATA_SYNC) begin
               state_d = DMAM_ST_SYNC;
            end
         end
         DMAM_ST_ORDER: begin
            if (drained) begin
               state_d = DMAM_ST_IDLE;
            end
         end
         DMAM_ST_SYNC: begin
            if (drained) begin
               state_d = DMAM_ST_IDLE;
            end
         end
         default: begin
            state_d = DMAM_ST_IDLE;
         end
      endcase
   end

   // Outstanding counters: one issue in, one done out per cycle.
   always_comb begin
      out_d    = out_q + DMAM_CNT_W'(take_ok) - DMAM_CNT_W'(dec);
      strong_d = strong_q + DMAM_CNT_W'(take_ok && d_strong)
                 - DMAM_CNT_W'(dec_strong);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q  <= DMAM_ST_IDLE;
         out_q    <= DMAM_CNT_RST;
         strong_q <= DMAM_CNT_RST;
      end else begin
         state_q  <= state_d;
         out_q    <= out_d;
         strong_q <= strong_d;
      end
   end

   // ============================================================
   // Fetch side and execution faults
   always_ff @(posedge clk) begin
      if (reset) begin
         fetch_attr_valid_q <= 1'b0;
         fetch_attr_q       <= '{DMAM_RG_CODE, DMAM_MT_NORMAL, 1'b0, 1'b0};
         xn_fault_q         <= 1'b0;
         flush_q            <= 1'b0;
         sync_done_q        <= 1'b0;
      end else begin
         fetch_attr_valid_q <= fetch_valid;
         if (fetch_valid) begin
            fetch_attr_q <= f_attr;
         end
         xn_fault_q  <= exec_valid && exec_ready && exec_xn;
         flush_q     <= (bar_take && bar_op == DMAM_BAR_INSTR_SYNC) || exc_entry;
         sync_done_q <= (state_q == DMAM_ST_SYNC) && drained;
      end
   end

   // ============================================================
   // Data issue
   always_ff @(posedge clk) begin
      if (reset) begin
         issue_valid_q <= 1'b0;
         issue_addr_q  <= 32'h0000_0000;
         issue_write_q <= 1'b0;
         issue_attr_q  <= '{DMAM_RG_CODE, DMAM_MT_NORMAL, 1'b0, 1'b0};
         issue_buf_q   <= 1'b0;
         bus_err_q     <= 1'b0;
      end else begin
         issue_valid_q <= take_ok;
         bus_err_q     <= take && d_attr.reserved;
         if (take_ok) begin
            issue_addr_q  <= req_addr;
            issue_write_q <= req_write;
            issue_attr_q  <= d_attr;
            issue_buf_q   <= req_write && d_device;
         end
      end
   end

   // ============================================================
   // Checks
   AST_RESV_ERR: assert property (@(posedge clk) disable iff (reset)
      take && d_attr.reserved |=> bus_err_q && !issue_valid_q)
      else $error("reserved access not refused");
   AST_PERI_DEV: assert property (@(posedge clk) disable iff (reset)
      take_ok && req_addr[31:29] == 3'h2 && !(data_prot.enable && data_prot.hit)
      |=> issue_attr_q.mtype == DMAM_MT_DEVICE && issue_attr_q.execute_never)
      else $error("peripheral not device xn");
   AST_XN_FAULT: assert property (@(posedge clk) disable iff (reset)
      exec_valid && exec_ready && exec_xn |=> xn_fault_q)
      else $error("no fault on xn execute");
   AST_PREFETCH: assert property (@(posedge clk) disable iff (reset)
      !exec_valid |=> !xn_fault_q)
      else $error("fault without execution");
   AST_STRONG_WAIT: assert property (@(posedge clk) disable iff (reset)
      take_ok && d_strong |-> out_q == DMAM_CNT_RST)
      else $error("strong access with outstanding");
   AST_NO_BUF: assert property (@(posedge clk) disable iff (reset)
      issue_valid_q && issue_attr_q.mtype == DMAM_MT_STRONG |-> !issue_buf_q)
      else $error("strong write buffered");
   AST_ORDER_BLOCK: assert property (@(posedge clk) disable iff (reset)
      state_q == DMAM_ST_ORDER |-> !req_ready)
      else $error("issue during order barrier");
   AST_BAR_BUSY: assert property (@(posedge clk) disable iff (reset)
      state_q != DMAM_ST_IDLE |-> !bar_ready && !take_ok)
      else $error("barrier or issue taken while draining");
   AST_ORDER_DRAIN: assert property (@(posedge clk) disable iff (reset)
      state_q == DMAM_ST_ORDER && drained |=> state_q == DMAM_ST_IDLE)
      else $error("order barrier did not end");
   AST_SYNC_STALL: assert property (@(posedge clk) disable iff (reset)
      state_q == DMAM_ST_SYNC && !drained |-> !exec_ready && !req_ready)
      else $error("execution during sync barrier");
   AST_SYNC_END: assert property (@(posedge clk) disable iff (reset)
      state_q == DMAM_ST_SYNC && drained |=> sync_done_q && exec_ready)
      else $error("sync barrier did not end");
   AST_FLUSH: assert property (@(posedge clk) disable iff (reset)
      bar_take && bar_op == DMAM_BAR_INSTR_SYNC |=> flush_q)
      else $error("no flush on instruction barrier");
   AST_PROT: assert property (@(posedge clk) disable iff (reset)
      fetch_valid && fetch_prot.enable && fetch_prot.hit && !f_attr.reserved
      |=> fetch_attr_q.execute_never == $past(fetch_prot.execute_never))
      else $error("protection override lost");
endmodule

//--- bench/dmam_core_model.sv
// Core-side partner model that completes issued transactions.
// Assumes the same clock as the map and one completion per cycle.
`timescale 1ns/1ps
module dmam_core_model (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic issue_valid_q,
   input  wire logic slow,
   output logic      done
);
   // ============================================================
   // Completion queue, prompt or slow.
   int unsigned due[$];
   int unsigned cyc = 0;
   always @(posedge clk) begin
      cyc  <= cyc + 1;
      done <= 1'b0;
      if (reset) begin
         due.delete();
      end else begin
         if (issue_valid_q) begin
            due.push_back(cyc + (slow ? 6 : 1));
         end
         if (due.size() > 0 && due[0] <= cyc) begin
            done <= 1'b1;
            void'(due.pop_front());
         end
      end
   end
endmodule

//--- bench/dmam_map_test.sv
// Testbench of the default memory attribute map.
// Assumes the package and the core model are compiled first.
`timescale 1ns/1ps
module dmam_map_test import dmam_pkg::*;;
   // ============================================================
   // Stimulus and observed signals.
   logic clk = 0, reset = 1, fetch_valid = 0, exec_valid = 0, exec_xn = 0;
   logic exc_entry = 0, req_valid = 0, req_write = 0, bar_valid = 0, slow = 0;
   logic [31:0] fetch_addr = 0, req_addr = 0, issue_addr_q;
   dmam_prot_t  fetch_prot = '0, data_prot = '0;
   dmam_bar_t   bar_op = DMAM_BAR_DATA_ORDER;
   dmam_attr_t  fetch_attr_q, issue_attr_q;
   logic fetch_attr_valid_q, exec_ready, xn_fault_q, flush_q, req_ready;
   logic issue_valid_q, issue_write_q, issue_buf_q, bus_err_q, done;
   logic bar_ready, sync_done_q;
   int   errors = 0, cmp_count = 0;
   always #5 clk = ~clk;
   dmam_map dmam_map_inst (.*);
   dmam_core_model dmam_core_model_inst (.*);
   // ============================================================
   // Shared tasks.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic dmam_attr_t att(dmam_region_t r, dmam_mtype_t m, logic x);
      return '{r, m, x, r == DMAM_RG_RESV};
   endfunction
   task automatic fetch_chk(input logic [31:0] a, input dmam_attr_t e);
      @(posedge clk);
      fetch_valid <= 1'b1;
      fetch_addr  <= a;
      @(posedge clk);
      fetch_valid <= 1'b0;
      #1;
      chk(fetch_attr_valid_q, 1'b1);
      chk(fetch_attr_q, e);
      chk(xn_fault_q, 1'b0);
   endtask
   task automatic req(input logic [31:0] a, input logic w, output int n);
      @(posedge clk);
      req_valid <= 1'b1;
      req_addr  <= a;
      req_write <= w;
      @(negedge clk);
      for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge clk);
      chk(req_ready, 1'b1);
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
   endtask
   task automatic bar(input dmam_bar_t op);
      @(posedge clk);
      bar_valid <= 1'b1;
      bar_op    <= op;
      @(negedge clk);
      for (int i = 0; i < 50 && bar_ready !== 1'b1; i++) @(negedge clk);
      chk(bar_ready, 1'b1);
      @(posedge clk);
      bar_valid <= 1'b0;
      #1;
   endtask
   // ============================================================
   // Scenarios.
   task automatic t_decode;
      fetch_chk(32'h0000_0000, att(DMAM_RG_CODE, DMAM_MT_NORMAL, 1'b0));
      fetch_chk(32'h1FFF_FFFF, att(DMAM_RG_CODE, DMAM_MT_NORMAL, 1'b0));
      fetch_chk(32'h2000_0000, att(DMAM_RG_SRAM, DMAM_MT_NORMAL, 1'b0));
      fetch_chk(32'h3FFF_FFFF, att(DMAM_RG_SRAM, DMAM_MT_NORMAL, 1'b0));
      fetch_chk(32'h4000_0000, att(DMAM_RG_PERI, DMAM_MT_DEVICE, 1'b1));
      fetch_chk(32'h5FFF_FFFF, att(DMAM_RG_PERI, DMAM_MT_DEVICE, 1'b1));
      fetch_chk(32'h6000_0000, att(DMAM_RG_XRAM, DMAM_MT_NORMAL, 1'b0));
      fetch_chk(32'h9FFF_FFFF, att(DMAM_RG_XRAM, DMAM_MT_NORMAL, 1'b0));
      fetch_chk(32'hA000_0000, att(DMAM_RG_XDEV, DMAM_MT_DEVICE, 1'b1));
      fetch_chk(32'hDFFF_FFFF, att(DMAM_RG_XDEV, DMAM_MT_DEVICE, 1'b1));
      fetch_chk(32'hE000_0000, att(DMAM_RG_PPB, DMAM_MT_STRONG, 1'b1));
      fetch_chk(32'hE00F_FFFF, att(DMAM_RG_PPB, DMAM_MT_STRONG, 1'b1));
      fetch_chk(32'hE010_0000, att(DMAM_RG_RESV, DMAM_MT_NONE, 1'b1));
      fetch_prot <= '{1'b1, 1'b1, DMAM_MT_STRONG, 1'b1};
      fetch_chk(32'h0000_1000, att(DMAM_RG_CODE, DMAM_MT_STRONG, 1'b1));
      fetch_prot <= '0;
   endtask
   task automatic t_data;
      int n;
      req(32'h4000_0010, 1'b1, n);
      chk(issue_attr_q.mtype, DMAM_MT_DEVICE);
      chk(issue_addr_q, 32'h4000_0010);
      chk(issue_write_q, 1'b1);
      chk(issue_valid_q, 1'b1);
      chk(issue_buf_q, 1'b1);
      req(32'hE000_E000, 1'b1, n);
      chk(issue_attr_q.mtype, DMAM_MT_STRONG);
      chk(issue_buf_q, 1'b0);
      req(32'hF000_0000, 1'b0, n);
      chk(bus_err_q, 1'b1);
      chk(issue_valid_q, 1'b0);
      data_prot <= '{1'b1, 1'b1, DMAM_MT_NORMAL, 1'b0};
      req(32'h4000_0020, 1'b0, n);
      chk(issue_attr_q.mtype, DMAM_MT_NORMAL);
      data_prot <= '0;
   endtask
   task automatic t_order;
      int n;
      slow <= 1'b1;
      req(32'hA000_0000, 1'b1, n);
      req(32'hE000_0000, 1'b1, n);
      chk(n > 2, 1'b1);
      req(32'h6000_0000, 1'b0, n);
      chk(n > 2, 1'b1);
      bar(DMAM_BAR_DATA_ORDER);
      req(32'h2000_0004, 1'b1, n);
      chk(n > 2, 1'b1);
      chk(issue_addr_q, 32'h2000_0004);
      bar(DMAM_BAR_DATA_SYNC);
      @(negedge clk);
      chk(exec_ready, 1'b0);
      for (int i = 0; i < 40 && sync_done_q !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk(sync_done_q, 1'b1);
      chk(exec_ready, 1'b1);
      @(negedge clk);
      chk(exec_ready, 1'b1);
      bar(DMAM_BAR_INSTR_SYNC);
      chk(flush_q, 1'b1);
      chk(exec_ready, 1'b1);
      @(posedge clk);
      exc_entry  <= 1'b1;
      exec_valid <= 1'b1;
      exec_xn    <= 1'b1;
      @(posedge clk);
      exc_entry  <= 1'b0;
      exec_valid <= 1'b0;
      exec_xn    <= 1'b0;
      #1;
      chk(flush_q, 1'b1);
      chk(xn_fault_q, 1'b1);
   endtask
   // ============================================================
   // Verdict, main sequence and watchdog.
   task automatic test_done;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      t_decode;
      t_data;
      t_order;
      test_done;
   end
   initial begin
      #100000;
      errors++;
      test_done;
   end
endmodule
